// ==== design/tac_abort_cause.sv ====
// Purpose: Records each transmit abort cause of the two-wire controller in a sticky bit.
// Assumes: Controller event inputs are on pclk; bus pins are asynchronous.
// Notes:   APB slave, zero wait states, read data latched in the setup cycle.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tac_regs.svh"

module tac_abort_cause (
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Bus pins
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   // Controller transmit state
   input  wire logic                      slave_transmitting,
   input  wire logic                      master_transmitting,
   input  wire logic                      intended_bit,
   // Controller slave events
   input  wire logic                      slave_read_pending,
   input  wire logic                      slave_read_command,
   input  wire logic                      tx_fifo_not_empty,
   // Controller acknowledge events
   input  wire logic                      ack_valid,
   input  wire tac_pkg::tac_ack_phase_type ack_phase,
   input  wire logic                      ack_received,
   input  wire logic                      transfer_done,
   // Results
   output logic                           transmit_abort_interrupt,
   output logic                           tx_fifo_flush,
   output logic                           master_transfer_start
);

   // Register state.
   logic [`TAC_CAUSE_W-1:0] cause_q;
   logic [`TAC_CAUSE_W-1:0] cause_d;
   logic [5:0]              control_q;
   logic [1:0]              target_q;
   logic                    sbyte_pending_q;
   logic                    addr_acked_q;
   logic                    gcall_sent_q;
   logic [31:0]             prdata_q;
   logic                    pslverr_q;
   logic                    flush_q;
   logic                    start_q;

   // Bus decode.
   wire setup_phase;
   wire access_phase;
   wire wr_access;
   wire hit_cause;
   wire hit_control;
   wire hit_target;
   wire hit_data_cmd;
   wire hit_clear;
   wire mapped;
   wire wr_control;
   wire wr_target;
   wire wr_data_cmd;
   wire abort_clear;

   // Configuration fields.
   wire master_en;
   wire ten_bit;
   wire high_speed;
   wire restart_en;
   wire start_byte_or_gc_select_enable;
   wire start_choice;

   // Event terms.
   wire                    bus_lost;
   wire                    slave_lost;
   wire                    master_lost;
   wire                    wr_read_dir;
   wire                    wr_gcall_read;
   wire                    master_attempt;
   wire                    sbyte_cause;
   wire                    gcall_mode;
   wire                    nack;
   wire [`TAC_CAUSE_W-1:0] cause_set;
   wire [`TAC_CAUSE_W-1:0] cause_clr;
   wire                    attempt_ok;
   wire                    ack_ok;
   wire                    ph_addr7;
   wire                    ph_ten1;
   wire                    ph_ten2;
   wire                    ph_data;
   wire                    ph_gcall;
   wire                    ph_start;
   wire                    ph_hs_code;

   // Set term of each abort cause bit for this cycle.
   wire                    set_slv_rd_dir;
   wire                    set_slv_lost;
   wire                    set_slv_flush;
   wire                    set_arbitration_loss_flag;
   wire                    set_master_dis;
   wire                    set_tenbit_rd;
   wire                    set_sbyte_nors;
   wire                    set_hs_nors;
   wire                    set_sbyte_ack;
   wire                    set_hs_ack;
   wire                    set_gcall_read;
   wire                    set_gcall_noack;
   wire                    set_data_noack;
   wire                    set_tenbit2;
   wire                    set_tenbit1;
   wire                    set_addr7;

   function automatic logic [31:0] tac_read_mux(
      input logic [31:0]             addr,
      input logic [`TAC_CAUSE_W-1:0] cause,
      input logic [5:0]              ctrl,
      input logic [1:0]              tgt
   );
      logic [31:0] r;
      r = 32'h00000000;
      if (addr == `TAC_ADDR_ABORT_CAUSE) begin
         r[`TAC_CAUSE_W-1:0] = cause;
      end else if (addr == `TAC_ADDR_CONTROL) begin
         r[5:0] = ctrl;
      end else if (addr == `TAC_ADDR_TARGET) begin
         r[`TAC_T_START_BYTE_OR_GC_SELECT_ENABLE]      = tgt[1];
         r[`TAC_T_START_CHOICE] = tgt[0];
      end
      return r;
   endfunction

   function automatic logic [`TAC_CAUSE_W-1:0] tac_onehot(input int unsigned pos);
      logic [`TAC_CAUSE_W-1:0] v;
      v = '0;
      v[pos[3:0]] = 1'b1;
      return v;
   endfunction

   tac_bus_ownership_check u_ownership (
      .pclk           (pclk),
      .presetn        (presetn),
      .scl_in         (scl_in),
      .sda_in         (sda_in),
      .transmitting   (slave_transmitting | master_transmitting),
      .intended_bit   (intended_bit),
      .bus_lost_pulse (bus_lost)
   );

   // APB decode: every access is answered at once; unmapped addresses error.
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access    = access_phase & pwrite;
   assign hit_cause    = (paddr == `TAC_ADDR_ABORT_CAUSE);
   assign hit_control  = (paddr == `TAC_ADDR_CONTROL);
   assign hit_target   = (paddr == `TAC_ADDR_TARGET);
   assign hit_data_cmd = (paddr == `TAC_ADDR_DATA_COMMAND);
   assign hit_clear    = (paddr == `TAC_ADDR_ABORT_CLEAR);
   assign mapped       = hit_cause | hit_control | hit_target | hit_data_cmd | hit_clear;
   assign wr_control   = wr_access & hit_control;
   assign wr_target    = wr_access & hit_target;
   assign wr_data_cmd  = wr_access & hit_data_cmd;
   assign abort_clear  = wr_access & hit_clear;
   assign pready       = access_phase;
   assign prdata       = prdata_q;
   assign pslverr      = pslverr_q & access_phase;

   assign master_en    = control_q[`TAC_C_MASTER_EN];
   assign ten_bit      = control_q[`TAC_C_TEN_BIT];
   assign high_speed   = control_q[`TAC_C_HIGH_SPEED];
   assign restart_en   = control_q[`TAC_C_RESTART_EN];
   assign start_byte_or_gc_select_enable      = target_q[1];
   assign start_choice = target_q[0];

   // A data/command write while a slave read is pending feeds the slave;
   // any other such write asks the master to start a transfer.
   assign wr_read_dir    = wr_data_cmd & slave_read_pending & pwdata[`TAC_DC_READ];
   assign master_attempt = wr_data_cmd & ~slave_read_pending;
   assign wr_gcall_read  = master_attempt & pwdata[`TAC_DC_GCALL_READ];
   assign gcall_mode     = start_byte_or_gc_select_enable & ~start_choice;
   assign sbyte_cause    = ~restart_en & start_byte_or_gc_select_enable & start_choice;
   assign slave_lost     = bus_lost & slave_transmitting;
   assign master_lost    = bus_lost & master_transmitting;
   assign nack           = ack_valid & ~ack_received;
   assign ack_ok         = ack_valid & ack_received;

   // One-hot decode of the phase that the acknowledge event belongs to.
   assign ph_addr7       = (ack_phase == tac_pkg::TAC_PH_ADDR7);
   assign ph_ten1        = (ack_phase == tac_pkg::TAC_PH_TEN1);
   assign ph_ten2        = (ack_phase == tac_pkg::TAC_PH_TEN2);
   assign ph_data        = (ack_phase == tac_pkg::TAC_PH_DATA);
   assign ph_gcall       = (ack_phase == tac_pkg::TAC_PH_GCALL);
   assign ph_start       = (ack_phase == tac_pkg::TAC_PH_START);
   assign ph_hs_code     = (ack_phase == tac_pkg::TAC_PH_HS_CODE);

   // The master start is withheld when any start-time abort applies, except bit 5 set by a read after an acked general call.
   assign attempt_ok = master_attempt & master_en
                       & ~(~restart_en & ten_bit & pwdata[`TAC_DC_READ])
                       & ~sbyte_cause
                       & ~(~restart_en & high_speed)
                       & ~(gcall_mode & pwdata[`TAC_DC_GCALL_READ]);

   // Start-time causes need an enabled master; a disabled one sets bit 11, and bit 5 for a read after an acked general call.
   assign set_slv_rd_dir  = wr_read_dir;
   assign set_slv_lost    = slave_lost;
   assign set_slv_flush   = slave_read_command & tx_fifo_not_empty;
   assign set_arbitration_loss_flag    = slave_lost | master_lost;
   assign set_master_dis  = master_attempt & ~master_en;
   assign set_tenbit_rd   = master_attempt & master_en & ~restart_en & ten_bit & pwdata[`TAC_DC_READ];
   assign set_sbyte_nors  = (master_attempt & master_en & sbyte_cause)
                            | (sbyte_pending_q & sbyte_cause & ~abort_clear);
   assign set_hs_nors     = master_attempt & master_en & ~restart_en & high_speed;
   assign set_sbyte_ack   = ack_ok & ph_start;
   assign set_hs_ack      = ack_ok & ph_hs_code;
   assign set_gcall_read  = wr_gcall_read & ((master_en & gcall_mode) | gcall_sent_q);
   assign set_gcall_noack = nack & ph_gcall;
   assign set_data_noack  = nack & addr_acked_q & master_en & ph_data;
   assign set_tenbit2     = nack & ph_ten2;
   assign set_tenbit1     = nack & ph_ten1;
   assign set_addr7       = nack & ph_addr7;

   assign cause_set = ({`TAC_CAUSE_W{set_slv_rd_dir}} & tac_onehot(`TAC_B_SLV_RD_DIR))
                    | ({`TAC_CAUSE_W{set_slv_lost}} & tac_onehot(`TAC_B_SLV_BUS_LOST))
                    | ({`TAC_CAUSE_W{set_slv_flush}} & tac_onehot(`TAC_B_SLV_FLUSH))
                    | ({`TAC_CAUSE_W{set_arbitration_loss_flag}} & tac_onehot(`TAC_B_ARBITRATION_LOSS_FLAG))
                    | ({`TAC_CAUSE_W{set_master_dis}} & tac_onehot(`TAC_B_MASTER_DIS))
                    | ({`TAC_CAUSE_W{set_tenbit_rd}} & tac_onehot(`TAC_B_TENBIT_RD_NORS))
                    | ({`TAC_CAUSE_W{set_sbyte_nors}} & tac_onehot(`TAC_B_SBYTE_NORS))
                    | ({`TAC_CAUSE_W{set_hs_nors}} & tac_onehot(`TAC_B_HS_NORS))
                    | ({`TAC_CAUSE_W{set_sbyte_ack}} & tac_onehot(`TAC_B_SBYTE_ACK))
                    | ({`TAC_CAUSE_W{set_hs_ack}} & tac_onehot(`TAC_B_HS_ACK))
                    | ({`TAC_CAUSE_W{set_gcall_read}} & tac_onehot(`TAC_B_GCALL_READ))
                    | ({`TAC_CAUSE_W{set_gcall_noack}} & tac_onehot(`TAC_B_GCALL_NOACK))
                    | ({`TAC_CAUSE_W{set_data_noack}} & tac_onehot(`TAC_B_DATA_NOACK))
                    | ({`TAC_CAUSE_W{set_tenbit2}} & tac_onehot(`TAC_B_TENBIT2_NOACK))
                    | ({`TAC_CAUSE_W{set_tenbit1}} & tac_onehot(`TAC_B_TENBIT1_NOACK))
                    | ({`TAC_CAUSE_W{set_addr7}} & tac_onehot(`TAC_B_ADDR7_NOACK));

   // A new cause in the clearing cycle survives the clear.
   assign cause_clr = {`TAC_CAUSE_W{abort_clear}};
   assign cause_d   = (cause_q & ~cause_clr) | cause_set;

   assign transmit_abort_interrupt = |cause_q;
   assign tx_fifo_flush            = flush_q;
   assign master_transfer_start    = start_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= `TAC_CAUSE_RESET;
      end else begin
         cause_q <= cause_d;
      end
   end

   // Flush and start are one-cycle pulses after the deciding edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         flush_q <= |(cause_set & ~cause_q);
         start_q <= attempt_ok;
      end
   end

   // Bit 9 keeps its cause in mind until software removes it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbyte_pending_q <= 1'b0;
      end else if (!sbyte_cause) begin
         sbyte_pending_q <= 1'b0;
      end else if (cause_set[`TAC_B_SBYTE_NORS]) begin
         sbyte_pending_q <= 1'b1;
      end
   end

   // Address acknowledge and general call tracking for the current transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_acked_q <= 1'b0;
         gcall_sent_q <= 1'b0;
      end else if (transfer_done) begin
         addr_acked_q <= 1'b0;
         gcall_sent_q <= 1'b0;
      end else if (ack_valid && ack_received && ack_phase != tac_pkg::TAC_PH_DATA) begin
         addr_acked_q <= 1'b1;
         gcall_sent_q <= (ack_phase == tac_pkg::TAC_PH_GCALL);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= `TAC_CONTROL_RESET;
      end else if (wr_control) begin
         control_q <= pwdata[5:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_q <= `TAC_TARGET_RESET;
      end else if (wr_target) begin
         target_q <= {pwdata[`TAC_T_START_BYTE_OR_GC_SELECT_ENABLE], pwdata[`TAC_T_START_CHOICE]};
      end
   end

   // Read data and error flag are latched in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup_phase) begin
         prdata_q  <= pwrite ? 32'h00000000 : tac_read_mux(paddr, cause_q, control_q, target_q);
         pslverr_q <= ~mapped | (pwrite & hit_cause);
      end
   end

endmodule

`default_nettype wire

// ==== design/tac_regs.svh ====
// Purpose: Register map, field positions and reset values of the transmit abort cause block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only; included by the design files.
`ifndef TAC_REGS_SVH
`define TAC_REGS_SVH

`define TAC_ADDR_ABORT_CAUSE     32'h50001480
`define TAC_ADDR_CONTROL         32'h500014a0
`define TAC_ADDR_TARGET          32'h500014a4
`define TAC_ADDR_DATA_COMMAND    32'h500014a8
`define TAC_ADDR_ABORT_CLEAR     32'h500014ac

`define TAC_CAUSE_W              16
`define TAC_CAUSE_RESET          16'h0000
`define TAC_CONTROL_RESET        6'h00
`define TAC_TARGET_RESET         2'h0

// Abort cause bit positions.
`define TAC_B_SLV_RD_DIR         15
`define TAC_B_SLV_BUS_LOST       14
`define TAC_B_SLV_FLUSH          13
`define TAC_B_ARBITRATION_LOSS_FLAG           12
`define TAC_B_MASTER_DIS         11
`define TAC_B_TENBIT_RD_NORS     10
`define TAC_B_SBYTE_NORS         9
`define TAC_B_HS_NORS            8
`define TAC_B_SBYTE_ACK          7
`define TAC_B_HS_ACK             6
`define TAC_B_GCALL_READ         5
`define TAC_B_GCALL_NOACK        4
`define TAC_B_DATA_NOACK         3
`define TAC_B_TENBIT2_NOACK      2
`define TAC_B_TENBIT1_NOACK      1
`define TAC_B_ADDR7_NOACK        0

// Control register fields.
`define TAC_C_MASTER_EN          0
`define TAC_C_TEN_BIT            1
`define TAC_C_HIGH_SPEED         2
`define TAC_C_RESTART_EN         5

// Target register fields.
`define TAC_T_START_BYTE_OR_GC_SELECT_ENABLE            11
`define TAC_T_START_CHOICE       10

// Data/command port fields.
`define TAC_DC_READ              8
`define TAC_DC_GCALL_READ        9

`endif

// ==== design/tac_pkg.sv ====
// Purpose: Types shared by the transmit abort cause block.
// Assumes: Nothing beyond the register header.
// Notes:   Phase codes are one-hot.
package tac_pkg;

   typedef enum logic [6:0] {
      TAC_PH_ADDR7     = 7'b0000001,
      TAC_PH_TEN1      = 7'b0000010,
      TAC_PH_TEN2      = 7'b0000100,
      TAC_PH_DATA      = 7'b0001000,
      TAC_PH_GCALL     = 7'b0010000,
      TAC_PH_START     = 7'b0100000,
      TAC_PH_HS_CODE   = 7'b1000000
   } tac_ack_phase_type;

endpackage

// ==== design/tac_bus_ownership_check.sv ====
// Purpose: Detects that the data line differs from the bit being driven at a clock-line rise.
// Assumes: Bus pins are asynchronous to pclk and pass two flip-flops first.
// Notes:   One-cycle pulse per mismatching clock-line rise while transmitting.
`timescale 1ns/10ps
`default_nettype none

module tac_bus_ownership_check (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Bus pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   // Transmitter state
   input  wire logic transmitting,
   input  wire logic intended_bit,
   // Result
   output logic      bus_lost_pulse
);

   logic scl_meta_q;
   logic scl_sync_q;
   logic scl_prev_q;
   logic sda_meta_q;
   logic sda_sync_q;
   logic lost_q;
   wire  scl_rise;
   wire  mismatch;

   assign scl_rise       = scl_sync_q & ~scl_prev_q;
   assign mismatch       = transmitting & scl_rise & (sda_sync_q != intended_bit);
   assign bus_lost_pulse = lost_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_meta_q <= 1'b1;
         scl_sync_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_meta_q <= 1'b1;
         sda_sync_q <= 1'b1;
         lost_q     <= 1'b0;
      end else begin
         scl_meta_q <= scl_in;
         scl_sync_q <= scl_meta_q;
         scl_prev_q <= scl_sync_q;
         sda_meta_q <= sda_in;
         sda_sync_q <= sda_meta_q;
         lost_q     <= mismatch;
      end
   end

endmodule

`default_nettype wire

// ==== bench/tac_abort_cause_checker.sv ====
// Purpose: Port-level checks of the transmit abort cause block.
// Assumes: Zero wait state APB slave; interrupt is the OR of all cause bits.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
`include "tac_regs.svh"

module tac_abort_cause_checker (
   // Clock and reset
   input wire logic                       pclk,
   input wire logic                       presetn,
   // APB
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                paddr,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   // Events and results
   input wire logic                       slave_read_command,
   input wire logic                       tx_fifo_not_empty,
   input wire logic                       ack_valid,
   input wire tac_pkg::tac_ack_phase_type ack_phase,
   input wire logic                       ack_received,
   input wire logic                       transmit_abort_interrupt,
   input wire logic                       tx_fifo_flush
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic clr = acc && pwrite && paddr == `TAC_ADDR_ABORT_CLEAR;
   wire logic nak = ack_valid && !ack_received;

   chk_addr7_noack: assert property (nak && ack_phase == tac_pkg::TAC_PH_ADDR7 |=> transmit_abort_interrupt)
      else $error("seven-bit address nack not recorded");
   chk_gcall_noack: assert property (nak && ack_phase == tac_pkg::TAC_PH_GCALL |=> transmit_abort_interrupt)
      else $error("general call nack not recorded");
   chk_sbyte_acked: assert property (ack_valid && ack_received && ack_phase == tac_pkg::TAC_PH_START
      |=> transmit_abort_interrupt) else $error("acked start byte not recorded");
   chk_hs_acked: assert property (ack_valid && ack_received && ack_phase == tac_pkg::TAC_PH_HS_CODE
      |=> transmit_abort_interrupt) else $error("acked high-speed code not recorded");
   chk_slave_flush: assert property (slave_read_command && tx_fifo_not_empty |=> transmit_abort_interrupt)
      else $error("stale fifo abort not raised");
   chk_flush_on_rise: assert property ($rose(transmit_abort_interrupt) |-> tx_fifo_flush)
      else $error("flush missing on new abort");
   chk_cause_sticky: assert property (transmit_abort_interrupt && !clr |=> transmit_abort_interrupt)
      else $error("abort cause dropped without clear");
   chk_read_cause: assert property (acc && !pwrite && paddr == `TAC_ADDR_ABORT_CAUSE
      |-> prdata[31:16] == 16'h0 && (|prdata[15:0]) == $past(transmit_abort_interrupt))
      else $error("cause read disagrees with interrupt");
   chk_cause_ro: assert property (acc && pwrite && paddr == `TAC_ADDR_ABORT_CAUSE |-> pready && pslverr)
      else $error("write to cause register not refused");

   cov_ack: cover property (nak);
   cov_flush: cover property (tx_fifo_flush);
   cov_clear: cover property (clr ##1 !transmit_abort_interrupt);
endmodule

bind tac_abort_cause tac_abort_cause_checker i_tac_abort_cause_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .slave_read_command(slave_read_command),
   .tx_fifo_not_empty(tx_fifo_not_empty), .ack_valid(ack_valid), .ack_phase(ack_phase),
   .ack_received(ack_received), .transmit_abort_interrupt(transmit_abort_interrupt),
   .tx_fifo_flush(tx_fifo_flush));
`default_nettype wire

// ==== bench/tac_bus_partner.sv ====
// Purpose: Remote bus device that clocks one bit on the two-wire bus.
// Assumes: Open-drain lines with pull-ups.
// Notes:   One frame: clock low 7 cycles, high 8, then released.
`timescale 1ns/10ps
`default_nettype none

module tac_bus_partner (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Frame request
   input  wire logic go,
   input  wire logic bit_val,
   // Bus lines
   output logic      scl_in,
   output logic      sda_in
);
   logic [3:0] cnt_q;
   logic       bit_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         bit_q <= 1'b1;
      end else if (go) begin
         cnt_q <= 4'h1;
         bit_q <= bit_val;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // Outside a frame both lines are released and the pull-ups hold them high.
   assign scl_in = (cnt_q == 4'h0) || cnt_q[3];
   assign sda_in = (cnt_q == 4'h0) || bit_q;
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench of the transmit abort cause block.
// Assumes: Zero wait state APB; cause bits set one edge after their event.
// Notes:   One task per scenario.
`timescale 1ns/10ps
`default_nettype none
`include "tac_regs.svh"

module tb;
   logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go, bit_val;
   logic [31:0]                paddr, pwdata, prdata, rd;
   logic                       scl_in, sda_in, slave_transmitting, master_transmitting, intended_bit;
   logic                       slave_read_pending, slave_read_command, tx_fifo_not_empty;
   logic                       ack_valid, ack_received, transfer_done;
   logic                       transmit_abort_interrupt, tx_fifo_flush, master_transfer_start;
   tac_pkg::tac_ack_phase_type ack_phase;
   int                         fail_count, cmp_count;

   tac_abort_cause i_tac_abort_cause (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_in), .sda_in(sda_in), .slave_transmitting(slave_transmitting),
      .master_transmitting(master_transmitting), .intended_bit(intended_bit),
      .slave_read_pending(slave_read_pending), .slave_read_command(slave_read_command),
      .tx_fifo_not_empty(tx_fifo_not_empty), .ack_valid(ack_valid), .ack_phase(ack_phase),
      .ack_received(ack_received), .transfer_done(transfer_done),
      .transmit_abort_interrupt(transmit_abort_interrupt), .tx_fifo_flush(tx_fifo_flush),
      .master_transfer_start(master_transfer_start));
   tac_bus_partner i_tac_bus_partner (.pclk(pclk), .presetn(presetn), .go(go), .bit_val(bit_val),
      .scl_in(scl_in), .sda_in(sda_in));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic expect_cause(input string name, input logic [15:0] exp);
      apb(1'b0, `TAC_ADDR_ABORT_CAUSE, 32'h0);
      check(name, rd, {16'h0, exp});
      apb(1'b1, `TAC_ADDR_ABORT_CLEAR, 32'h0);
   endtask

   task automatic t_regs();
      expect_cause("cause reset", 16'h0);
      apb(1'b1, `TAC_ADDR_ABORT_CAUSE, 32'hffff);
      check("cause write error", {31'h0, er}, 32'h1);
      apb(1'b0, 32'h50001484, 32'h0);
      check("unmapped error", {31'h0, er}, 32'h1);
      expect_cause("cause unchanged", 16'h0);
   endtask

   task automatic t_ack();
      logic [6:0]  ph [9] = '{7'h08, 7'h01, 7'h02, 7'h04, 7'h10, 7'h20, 7'h40, 7'h01, 7'h08};
      logic [8:0]  ak = 9'b011100000;
      logic [15:0] ex [9] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h10, 16'h80, 16'h40, 16'h0, 16'h8};
      apb(1'b1, `TAC_ADDR_CONTROL, 32'h1);
      for (int i = 0; i < 9; i++) begin
         @(posedge pclk);
         ack_valid <= 1'b1;
         ack_phase <= tac_pkg::tac_ack_phase_type'(ph[i]);
         ack_received <= ak[i];
         @(posedge pclk);
         ack_valid <= 1'b0;
         #1;
         check("ack flush", {31'h0, tx_fifo_flush}, {31'h0, ex[i] != 16'h0});
         expect_cause("ack cause", ex[i]);
      end
   endtask

   task automatic t_cfg();
      logic [5:0]  c [6] = '{6'h00, 6'h03, 6'h05, 6'h01, 6'h27, 6'h00};
      logic [1:0]  t [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0};
      logic [9:0]  d [6] = '{10'h0, 10'h100, 10'h0, 10'h200, 10'h100, 10'h100};
      logic [15:0] ex [6] = '{16'h0800, 16'h0400, 16'h0100, 16'h0020, 16'h0, 16'h8000};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `TAC_ADDR_CONTROL, {26'h0, c[i]});
         apb(1'b1, `TAC_ADDR_TARGET, {20'h0, t[i], 10'h0});
         slave_read_pending <= (i == 5);
         apb(1'b1, `TAC_ADDR_DATA_COMMAND, {22'h0, d[i]});
         slave_read_pending <= 1'b0;
         #1;
         check("transfer start", {31'h0, master_transfer_start}, {31'h0, ex[i] == 16'h0});
         apb(1'b1, `TAC_ADDR_TARGET, 32'h0);
         expect_cause("config cause", ex[i]);
      end
   endtask

   task automatic t_restart();
      apb(1'b1, `TAC_ADDR_CONTROL, 32'h1);
      apb(1'b1, `TAC_ADDR_TARGET, 32'hc00);
      apb(1'b1, `TAC_ADDR_DATA_COMMAND, 32'h0);
      expect_cause("start byte cause", 16'h0200);
      apb(1'b1, `TAC_ADDR_TARGET, 32'h0);
      expect_cause("start byte kept", 16'h0200);
      expect_cause("start byte fixed", 16'h0);
   endtask

   task automatic t_slave();
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         tx_fifo_not_empty <= (i == 0);
         slave_read_command <= 1'b1;
         @(posedge pclk);
         slave_read_command <= 1'b0;
         #1;
         check("slave flush", {31'h0, tx_fifo_flush}, {31'h0, i == 0});
         check("slave interrupt", {31'h0, transmit_abort_interrupt}, {31'h0, i == 0});
         expect_cause("slave cause", (i == 0) ? 16'h2000 : 16'h0);
      end
   endtask

   task automatic t_bus();
      logic [15:0] ex [4] = '{16'h5000, 16'h1000, 16'h0, 16'h5000};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         slave_transmitting <= (i != 1);
         master_transmitting <= (i == 1);
         bit_val <= (i >= 2);
         intended_bit <= (i != 3);
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         repeat (24) @(posedge pclk);
         slave_transmitting <= 1'b0;
         master_transmitting <= 1'b0;
         expect_cause("bus lost cause", ex[i]);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin
      {presetn, psel, penable, pwrite, go, bit_val, slave_transmitting, master_transmitting} = 8'h0;
      {slave_read_pending, slave_read_command, tx_fifo_not_empty, ack_valid, ack_received} = 5'h0;
      {transfer_done, intended_bit, paddr, pwdata} = {2'b01, 64'h0};
      ack_phase = tac_pkg::TAC_PH_ADDR7;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ack();
      t_cfg();
      t_restart();
      t_slave();
      t_bus();
      summarize();
   end

   initial begin
      #200000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
